//--- shared/spi_shift_pkg.sv
// Purpose: Constants and types shared by the synchronous serial port.
// Assumes: Register indices are word indices; byte address is four times the index.
// Notes: Reset values of all control fields are zero.
package spi_shift_pkg;
  localparam int BUS_W = 32;
  localparam int IDX_W = 6;
  localparam logic [5:0] IDX_BANK = 6'h03;
  localparam logic [5:0] IDX_CTRL_A = 6'h05;
  localparam logic [5:0] IDX_CTRL_B = 6'h06;
  localparam logic [5:0] IDX_DATA = 6'h07;
  localparam logic [5:0] IDX_IF_MODE = 6'h08;
  localparam logic [5:0] IDX_IRQ_STAT = 6'h09;
  localparam logic [5:0] IDX_IRQ_CLR = 6'h0A;
  localparam logic [5:0] IDX_IRQ_EN = 6'h0B;
  localparam int BANK_HI = 7;
  localparam int BANK_LO = 6;
  localparam logic [1:0] BANK_SERIAL = 2'h3;
  localparam int IF_MODE_HI = 5;
  localparam int IF_MODE_LO = 4;
  localparam logic [1:0] IF_MODE_SYNC = 2'h1;
  localparam int A_SMP = 7;
  localparam int A_COL = 6;
  localparam int A_RATE_HI = 5;
  localparam int A_RATE_LO = 3;
  localparam int A_EDS = 2;
  localparam int A_ORD = 1;
  localparam int A_PEND = 0;
  localparam int B_START = 7;
  localparam int B_MODE_HI = 2;
  localparam int B_MODE_LO = 1;
  localparam int B_RBF = 0;
  localparam logic [1:0] RATE_EXT = 2'h3;
  localparam logic [1:0] XFER_DUPLEX = 2'h0;
  localparam logic [1:0] XFER_TX = 2'h1;
  localparam logic [1:0] XFER_RX = 2'h2;
  localparam logic [1:0] XFER_RSVD = 2'h3;
  localparam int DIV_W = 13;
  // Half of one serial bit period, in system clocks, for rate codes 0 to 5
  localparam logic [12:0] HALF_DIV_0 = 13'h1000;
  localparam logic [12:0] HALF_DIV_1 = 13'h0400;
  localparam logic [12:0] HALF_DIV_2 = 13'h0200;
  localparam logic [12:0] HALF_DIV_3 = 13'h0080;
  localparam logic [12:0] HALF_DIV_4 = 13'h0020;
  localparam logic [12:0] HALF_DIV_5 = 13'h0010;
  localparam logic [3:0] LAST_HALF = 4'hF;
  localparam int IRQ_W = 2;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_COL = 1;
  localparam logic [7:0] RST_BYTE = 8'h00;
  typedef enum logic {ST_IDLE, ST_SHIFT} shift_state_t;
endpackage

//--- rtl/spi_rate_divider.sv
// Purpose: Half-bit-period tick generator for the internal serial clock.
// Assumes: run_in stays high for a whole transfer.
// Notes: Restarts from zero whenever run_in is low, so the first half period is full length.
`timescale 1ns/10ps
`default_nettype none
module spi_rate_divider
  import spi_shift_pkg::*;
(
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic run_in,
  input wire logic [2:0] rate_sel_in,
  output logic half_tick_out
);
  logic [DIV_W-1:0] count;
  logic [DIV_W-1:0] next_count;
  logic [DIV_W-1:0] limit;
  logic next_tick;

  always_comb begin
    unique case (rate_sel_in)
      3'h0: limit = HALF_DIV_0;
      3'h1: limit = HALF_DIV_1;
      3'h2: limit = HALF_DIV_2;
      3'h3: limit = HALF_DIV_3;
      3'h4: limit = HALF_DIV_4;
      default: limit = HALF_DIV_5;
    endcase
    next_tick = 1'b0;
    next_count = '0;
    if (run_in) begin
      if (count == limit - 13'h0001) begin
        next_tick = 1'b1;
      end else begin
        next_count = count + 13'h0001;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      count <= '0;
      half_tick_out <= 1'b0;
    end else begin
      count <= next_count;
      half_tick_out <= next_tick;
    end
  end
endmodule
`default_nettype wire

//--- rtl/spi_shift_controller.sv
// Purpose: Byte-wide synchronous serial port with AHB-Lite register access.
// Assumes: Single word transfers with an idle cycle between them; pins synchronous to clock_in.
// Notes: Zero wait states; a transfer needs its own start write.
// Notes on behaviour
// - Internal clock: sample mid or end per bit.
// - External clock: always sample at mid bit.
// - Collision flag sticky until software writes zero.
// - Rate field picks divider or external clock.
// - Shift edge selects rising or falling output.
// - Bit order selects MSB or LSB first.
// - Pending flag sets when data buffer written.
// - Start bit begins shift, clears when done.
// - Mode field: duplex, transmit only, receive only.
// - Receive full sets on byte, clears on read.
// - Enabling the port clears receive full.
// - Port registers reachable only in bank three.
// - Port works only when interface mode synchronous.
//
// Our own choice: the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module spi_shift_controller
  import spi_shift_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic hsel_in,
  input wire logic [ADDR_W-1:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [spi_shift_pkg::BUS_W-1:0] hwdata_in,
  input wire logic hready_in,
  output logic [spi_shift_pkg::BUS_W-1:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe_out,
  input wire logic sdi_in,
  output logic sdo_out,
  output logic sdo_oe_out,
  output logic irq_out
);
  shift_state_t state, next_state;
  logic [7:0] bank, next_bank;
  logic [1:0] if_mode, next_if_mode;
  logic sample_phase_sel, next_smp, col, next_col, shift_edge_sel, next_eds, order, next_order;
  logic [2:0] rate, next_rate;
  logic pend, next_pend, rx_buffer_full, next_rbf;
  logic [1:0] mode, next_mode;
  logic [7:0] tx_hold, next_tx_hold, rx_data, next_rx_data, sh, next_sh;
  logic rx_bit, next_rx_bit;
  logic [3:0] half_cnt, next_half_cnt;
  logic sck_q, next_sck, sdo_q, next_sdo, sck_in_q;
  logic [IRQ_W-1:0] stat, next_stat, irq_en, next_irq_en;
  logic irq_q, next_irq;
  logic [BUS_W-1:0] hrdata_q, next_hrdata;
  logic wr_pend, next_wr_pend;
  logic [IDX_W-1:0] wr_idx, next_wr_idx;
  logic [IDX_W-1:0] idx;
  logic [7:0] wd, shifted;
  logic acc, bank_ok, rd_data_acc, port_en, ext_sel, half_tick;
  logic ext_a, ext_b, ev_a, ev_b, in_bit, finish, start_go, en_rise;

  assign idx = haddr_in[IDX_W+1:2];
  assign wd = hwdata_in[7:0];
  assign acc = hsel_in & htrans_in[1] & hready_in;
  assign bank_ok = bank[BANK_HI:BANK_LO] == BANK_SERIAL;
  assign rd_data_acc = acc & ~hwrite_in & (idx == IDX_DATA) & bank_ok;
  assign port_en = if_mode == IF_MODE_SYNC;
  assign ext_sel = rate[2:1] == RATE_EXT;
  // Shift edge is the one that leaves sck at its idle level; the other is mid bit
  assign ext_a = shift_edge_sel ? (sck_in & ~sck_in_q) : (~sck_in & sck_in_q);
  assign ext_b = shift_edge_sel ? (~sck_in & sck_in_q) : (sck_in & ~sck_in_q);
  assign ev_a = (state == ST_SHIFT) & (ext_sel ? ext_a : (half_tick & ~half_cnt[0]));
  assign ev_b = (state == ST_SHIFT) & (ext_sel ? ext_b : (half_tick & half_cnt[0]));
  // End-of-bit sampling reads the pin live; the external clock never does
  assign in_bit = (sample_phase_sel & ~ext_sel) ? sdi_in : rx_bit;
  assign shifted = order ? {in_bit, sh[7:1]} : {sh[6:0], in_bit};
  assign finish = ev_b & (half_cnt == LAST_HALF);
  assign start_go = wr_pend & bank_ok & (wr_idx == IDX_CTRL_B) & wd[B_START] & (state == ST_IDLE) & port_en
                    & (wd[B_MODE_HI:B_MODE_LO] != XFER_RSVD);
  assign en_rise = wr_pend & (wr_idx == IDX_IF_MODE) & (wd[IF_MODE_HI:IF_MODE_LO] == IF_MODE_SYNC) & ~port_en;

  spi_rate_divider u_div (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .run_in((state == ST_SHIFT) & ~ext_sel),
    .rate_sel_in(rate),
    .half_tick_out(half_tick)
  );

  always_comb begin
    next_state = state;
    next_bank = bank;
    next_if_mode = if_mode;
    next_smp = sample_phase_sel;
    next_col = col;
    next_rate = rate;
    next_eds = shift_edge_sel;
    next_order = order;
    next_pend = pend;
    next_rbf = rx_buffer_full;
    next_mode = mode;
    next_tx_hold = tx_hold;
    next_rx_data = rx_data;
    next_sh = sh;
    next_rx_bit = rx_bit;
    next_half_cnt = half_cnt;
    next_sck = sck_q;
    next_sdo = sdo_q;
    next_stat = stat;
    next_irq_en = irq_en;
    next_irq = |(stat & irq_en);
    next_wr_pend = acc & hwrite_in;
    next_wr_idx = idx;
    next_hrdata = '0;
    // Read data is fetched in the address phase so it stands for the whole data phase
    if (acc & ~hwrite_in) begin
      unique case (idx)
        IDX_BANK: next_hrdata[7:0] = bank;
        IDX_IF_MODE: next_hrdata[IF_MODE_HI:IF_MODE_LO] = if_mode;
        IDX_IRQ_STAT: next_hrdata[IRQ_W-1:0] = stat;
        IDX_IRQ_EN: next_hrdata[IRQ_W-1:0] = irq_en;
        IDX_CTRL_A: if (bank_ok) begin
          next_hrdata[7:0] = {sample_phase_sel, col, rate, shift_edge_sel, order, pend};
        end
        IDX_CTRL_B: if (bank_ok) begin
          next_hrdata[7:0] = {state == ST_SHIFT, 4'h0, mode, rx_buffer_full};
        end
        IDX_DATA: if (bank_ok) begin
          next_hrdata[7:0] = rx_data;
        end
        default: next_hrdata = '0;
      endcase
    end
    if (rd_data_acc) begin
      next_rbf = 1'b0;
    end
    if (wr_pend) begin
      unique case (wr_idx)
        IDX_BANK: next_bank = wd;
        IDX_IF_MODE: next_if_mode = wd[IF_MODE_HI:IF_MODE_LO];
        IDX_IRQ_CLR: next_stat = stat & ~wd[IRQ_W-1:0];
        IDX_IRQ_EN: next_irq_en = wd[IRQ_W-1:0];
        IDX_CTRL_A: if (bank_ok) begin
          next_smp = wd[A_SMP];
          next_rate = wd[A_RATE_HI:A_RATE_LO];
          next_eds = wd[A_EDS];
          next_order = wd[A_ORD];
          if (!wd[A_COL]) begin
            next_col = 1'b0;
          end
        end
        IDX_CTRL_B: if (bank_ok) begin
          next_mode = wd[B_MODE_HI:B_MODE_LO];
        end
        IDX_DATA: if (bank_ok) begin
          next_tx_hold = wd;
          next_pend = 1'b1;
        end
        default: next_bank = bank;
      endcase
    end
    if (en_rise) begin
      next_rbf = 1'b0;
    end
    unique case (state)
      ST_IDLE: begin
        next_sck = ~shift_edge_sel;
        next_half_cnt = 4'h0;
        if (start_go) begin
          next_state = ST_SHIFT;
          next_sh = tx_hold;
          next_pend = 1'b0;
          next_sdo = order ? tx_hold[0] : tx_hold[7];
        end
      end
      ST_SHIFT: begin
        if (!port_en) begin
          next_state = ST_IDLE;
        end else if (ev_a) begin
          next_half_cnt = half_cnt + 4'h1;
          next_sck = ext_sel ? sck_q : ~sck_q;
          if (ext_sel || !sample_phase_sel) begin
            next_rx_bit = sdi_in;
          end
        end else if (ev_b) begin
          next_half_cnt = half_cnt + 4'h1;
          next_sck = ext_sel ? sck_q : ~sck_q;
          next_sh = shifted;
          next_sdo = order ? shifted[0] : shifted[7];
          if (finish) begin
            next_state = ST_IDLE;
            next_stat[IRQ_DONE] = 1'b1;
            if (mode != XFER_TX) begin
              next_rx_data = shifted;
              next_rbf = 1'b1;
              // An unread byte is overwritten; software is expected to read in time
              if (rx_buffer_full && !rd_data_acc) begin
                next_col = 1'b1;
                next_stat[IRQ_COL] = 1'b1;
              end
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      state <= ST_IDLE;
      bank <= RST_BYTE;
      if_mode <= 2'h0;
      sample_phase_sel <= 1'b0;
      col <= 1'b0;
      rate <= 3'h0;
      shift_edge_sel <= 1'b0;
      order <= 1'b0;
      pend <= 1'b0;
      rx_buffer_full <= 1'b0;
      mode <= XFER_DUPLEX;
      tx_hold <= RST_BYTE;
      rx_data <= RST_BYTE;
      sh <= RST_BYTE;
      rx_bit <= 1'b0;
      half_cnt <= 4'h0;
      sck_q <= 1'b1;
      sdo_q <= 1'b0;
      sck_in_q <= 1'b1;
      stat <= '0;
      irq_en <= '0;
      irq_q <= 1'b0;
      hrdata_q <= '0;
      wr_pend <= 1'b0;
      wr_idx <= '0;
      sck_oe_out <= 1'b0;
      sdo_oe_out <= 1'b0;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end else begin
      state <= next_state;
      bank <= next_bank;
      if_mode <= next_if_mode;
      sample_phase_sel <= next_smp;
      col <= next_col;
      rate <= next_rate;
      shift_edge_sel <= next_eds;
      order <= next_order;
      pend <= next_pend;
      rx_buffer_full <= next_rbf;
      mode <= next_mode;
      tx_hold <= next_tx_hold;
      rx_data <= next_rx_data;
      sh <= next_sh;
      rx_bit <= next_rx_bit;
      half_cnt <= next_half_cnt;
      sck_q <= next_sck;
      sdo_q <= next_sdo;
      sck_in_q <= sck_in;
      stat <= next_stat;
      irq_en <= next_irq_en;
      irq_q <= next_irq;
      hrdata_q <= next_hrdata;
      wr_pend <= next_wr_pend;
      wr_idx <= next_wr_idx;
      sck_oe_out <= (next_if_mode == IF_MODE_SYNC) & (next_rate[2:1] != RATE_EXT);
      sdo_oe_out <= (next_if_mode == IF_MODE_SYNC) & (next_mode != XFER_RX);
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end
  end

  assign hrdata_out = hrdata_q;
  assign sck_out = sck_q;
  assign sdo_out = sdo_q;
  assign irq_out = irq_q;

  // Helper counters for the checks below
  logic [3:0] bits_seen;
  logic [DIV_W-1:0] gap;
  logic [DIV_W-1:0] half_ref;
  always_ff @(posedge clock_in) begin
    if (srst_in || state == ST_IDLE) begin
      bits_seen <= 4'h0;
      gap <= '0;
    end else begin
      bits_seen <= ev_b ? bits_seen + 4'h1 : bits_seen;
      gap <= (sck_q != next_sck) ? '0 : gap + 13'h0001;
    end
  end
  always_comb begin
    unique case (rate)
      3'h0: half_ref = HALF_DIV_0;
      3'h1: half_ref = HALF_DIV_1;
      3'h2: half_ref = HALF_DIV_2;
      3'h3: half_ref = HALF_DIV_3;
      3'h4: half_ref = HALF_DIV_4;
      default: half_ref = HALF_DIV_5;
    endcase
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);

  chk_rbf_read_clear: assert property (rd_data_acc && !finish |=> !rx_buffer_full)
    else $error("receive full not cleared by data read");
  chk_collision_sticky: assert property (col && !(wr_pend && wr_idx == IDX_CTRL_A && bank_ok && !wd[A_COL]) |=> col)
    else $error("collision flag dropped without software clear");
  chk_pending_set: assert property (wr_pend && wr_idx == IDX_DATA && bank_ok |=> pend)
    else $error("pending flag not set by data write");
  chk_start_done: assert property (finish && port_en |=> state == ST_IDLE && sck_q == ~shift_edge_sel)
    else $error("shift did not end after last edge");
  chk_eight_bits: assert property (finish |-> bits_seen == 4'h7)
    else $error("transfer did not shift eight bits");
  // First half period runs one cycle long while the divider restarts
  chk_sck_rate: assert property (state == ST_SHIFT && !ext_sel && $past(state) == ST_SHIFT && $changed(sck_q)
                                 |-> $past(gap) + 13'h0001 == half_ref || $past(gap) == half_ref)
    else $error("internal clock half period wrong");
  chk_shift_edge: assert property (state == ST_SHIFT && !ext_sel && $changed(sdo_q) && $past(state) == ST_SHIFT
                                   |-> sck_q == ~shift_edge_sel)
    else $error("data changed off the shift edge");
  chk_first_bit: assert property (start_go |=> sdo_q == (order ? $past(tx_hold[0]) : $past(tx_hold[7])))
    else $error("first bit does not follow bit order");
  chk_bank_gate: assert property (acc && !hwrite_in && !bank_ok
                                  && (idx == IDX_CTRL_A || idx == IDX_CTRL_B || idx == IDX_DATA)
                                  |=> hrdata_q == '0)
    else $error("port register readable outside its bank");
  chk_enable_clear: assert property (en_rise && !finish |=> !rx_buffer_full)
    else $error("enabling port left receive full set");
  chk_sck_drive: assert property (sck_oe_out == (port_en && !ext_sel))
    else $error("clock pin driven under external clock");
  cov_duplex_done: cover property (finish && mode == XFER_DUPLEX);
  cov_collision: cover property ($rose(col));
  cov_ext_done: cover property (finish && ext_sel);
  cov_lsb_first: cover property (start_go && order);
endmodule
`default_nettype wire

//--- bench/spi_peer_model.sv
// Purpose: Serial peer that answers frames clocked by the port or by the bench.
// Assumes: The port or, under external clock, the bench drives the serial clock; the peer never does.
// Notes: Data in changes three cycles after a shift edge, giving the port hold time.
`timescale 1ns/10ps
`default_nettype none
module spi_peer_model (
  input wire logic clock_in,
  input wire logic sck_in,
  input wire logic sdo_in,
  input wire logic edge_sel_in,
  input wire logic order_sel_in,
  input wire logic load_in,
  input wire logic [7:0] byte_in,
  output logic sdi_out,
  output logic [7:0] rx_byte_out
);
  logic sck_q = 1'b1;
  logic [7:0] sh = 8'h00;
  logic [1:0] hold = 2'h0;
  logic sdi_q = 1'b0;
  logic [7:0] rx_q = 8'h00;
  assign sdi_out = sdi_q;
  assign rx_byte_out = rx_q;
  always @(posedge clock_in) begin
    sck_q <= sck_in;
    if (load_in) begin
      sh <= byte_in;
      sdi_q <= order_sel_in ? byte_in[0] : byte_in[7];
    end else if (sck_in != sck_q && sck_in == edge_sel_in) begin
      rx_q <= order_sel_in ? {sdo_in, rx_q[7:1]} : {rx_q[6:0], sdo_in};
    end else if (sck_in != sck_q) begin
      // Inverted fill so a line past its last bit never repeats it
      sh <= order_sel_in ? {~sh[0], sh[7:1]} : {sh[6:0], ~sh[7]};
      hold <= 2'h2;
    end
    if (hold == 2'h1) sdi_q <= order_sel_in ? sh[0] : sh[7];
    if (hold != 2'h0) hold <= hold - 2'h1;
  end
endmodule
`default_nettype wire

//--- bench/spi_shift_controller_tb.sv
// Purpose: Self-checking bench for the serial port, its registers and interrupt.
// Assumes: Zero-wait bus slave; one idle cycle between bus transfers.
// Notes: Fast rate codes keep frames short.
`timescale 1ns/10ps
`default_nettype none
module spi_shift_controller_tb;
  import spi_shift_pkg::*;
  localparam logic [7:0] A_BANK = {IDX_BANK, 2'b00};
  localparam logic [7:0] A_CA = {IDX_CTRL_A, 2'b00};
  localparam logic [7:0] A_CB = {IDX_CTRL_B, 2'b00};
  localparam logic [7:0] A_DAT = {IDX_DATA, 2'b00};
  localparam logic [7:0] A_IFM = {IDX_IF_MODE, 2'b00};
  localparam logic [7:0] A_STAT = {IDX_IRQ_STAT, 2'b00};
  localparam logic [7:0] A_CLR = {IDX_IRQ_CLR, 2'b00};
  localparam logic [7:0] A_EN = {IDX_IRQ_EN, 2'b00};
  logic clock_in = 1'b0;
  logic srst_in = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] obs = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, sck_out, sck_oe, sdo, sdo_oe, irq, sdi, sck_wire, sdo_wire;
  logic edge_sel = 1'b0;
  logic order_sel = 1'b0;
  logic load = 1'b0;
  logic ext_sck = 1'b1;
  logic obsv = 1'b0;
  logic [7:0] peer_tx = 8'h00;
  logic [7:0] seed = 8'h26;
  logic [7:0] peer_rx;
  logic [31:0] expq[$];
  int num_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  // The bench clocks the line when the port leaves it; the data line is pulled up
  assign sck_wire = sck_oe ? sck_out : ext_sck;
  assign sdo_wire = sdo_oe ? sdo : 1'b1;
  spi_shift_controller DUT (.clock_in(clock_in), .srst_in(srst_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hreadyout),
    .hrdata_out(hrdata), .hreadyout_out(hreadyout), .hresp_out(hresp), .sck_in(sck_wire), .sck_out(sck_out),
    .sck_oe_out(sck_oe), .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_out(sdo_oe), .irq_out(irq));
  spi_peer_model peer (.clock_in(clock_in), .sck_in(sck_wire), .sdo_in(sdo_wire), .edge_sel_in(edge_sel),
    .order_sel_in(order_sel), .load_in(load), .byte_in(peer_tx), .sdi_out(sdi), .rx_byte_out(peer_rx));
  initial begin
    forever #5 clock_in = ~clock_in;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic complete_run();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    expq.push_back(exp);
    obs <= got;
    obsv <= 1'b1;
    @(posedge clock_in);
    obsv <= 1'b0;
    @(posedge clock_in);
  endtask
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (obsv === 1'b1) begin
      checks_done++;
      if (obs !== expq[0]) begin
        num_errors++;
        $display("unexpected at time %0t got %h expected %h", $time, obs, expq[0]);
      end
      void'(expq.pop_front());
    end
    if (cyc == 60000) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clock_in); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock_in); while (hreadyout !== 1'b1);
    rd = hrdata;
    hsel <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, a, {24'h0, d}, r);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, {24'h0, e});
  endtask
  task automatic irqchk(input logic e);
    @(posedge clock_in);
    chk({31'h0, irq}, {31'h0, e});
  endtask
  task automatic xfer(input logic [7:0] ca, input logic [1:0] mode, input logic rd_back, input logic col);
    logic [31:0] r;
    logic [7:0] tx;
    logic [7:0] px;
    int t0;
    int half;
    logic ext;
    tx = seed;
    px = lfsr(seed);
    seed = lfsr(px);
    ext = ca[A_RATE_HI -: 2] == RATE_EXT;
    half = ext ? 20 : (ca[A_RATE_LO] ? 16 : 32);
    wr(A_CA, ca);
    wr(A_DAT, tx);
    rdchk(A_CA, ca | 8'h01);
    edge_sel <= ca[A_EDS];
    order_sel <= ca[A_ORD];
    peer_tx <= px;
    load <= 1'b1;
    @(posedge clock_in);
    load <= 1'b0;
    wr(A_CB, {1'b1, 4'h0, mode, 1'b0});
    t0 = cyc;
    // External clock: sixteen edges, idle high, still between frames
    for (int k = 0; k < 16 && ext; k++) begin
      repeat (20) @(posedge clock_in);
      ext_sck <= ~ext_sck;
    end
    r = 32'hFF;
    for (int i = 0; i < 400 && r[B_START] === 1'b1; i++) bus(1'b0, A_CB, 32'h0, r);
    chk({31'h0, r[B_START]}, 32'h0);
    chk(32'((cyc - t0) >= 16 * half - 4 && (cyc - t0) <= 18 * half + 40), 32'h1);
    chk({29'h0, hresp, sck_oe, sdo_oe}, {29'h0, 1'b0, !ext, mode != XFER_RX});
    rdchk(A_CA, ca | {1'b0, col, 6'h0});
    if (mode != XFER_RX) chk({24'h0, peer_rx}, {24'h0, tx});
    if (mode != XFER_TX) rdchk(A_CB, {5'h0, mode, 1'b1});
    if (rd_back) begin
      bus(1'b0, A_DAT, 32'h0, r);
      if (mode != XFER_TX) chk(r, {24'h0, px});
      rdchk(A_CB, {5'h0, mode, 1'b0});
    end
  endtask
  initial begin
    logic [7:0] ca;
    repeat (10) @(posedge clock_in);
    srst_in <= 1'b0;
    @(posedge clock_in);
    wr(A_CA, 8'hFF);
    rdchk(A_CA, 8'h00);
    wr(A_BANK, 8'hC0);
    rdchk(A_CA, 8'h00);
    wr(A_CB, 8'h80);
    rdchk(A_CB, 8'h00);
    wr(A_IFM, 8'h10);
    wr(A_EN, 8'h03);
    wr(A_CB, 8'h86);
    rdchk(A_CB, 8'h06);
    for (int i = 0; i < 8; i++) begin
      ca = {i[2], 1'b0, 2'b10, i[1] ^ i[2], i[1], i[0], 1'b0};
      xfer(ca, 2'(i % 3), 1'b1, 1'b0);
    end
    xfer(8'hB0, XFER_DUPLEX, 1'b1, 1'b0);
    xfer(8'h28, XFER_DUPLEX, 1'b0, 1'b0);
    xfer(8'h28, XFER_DUPLEX, 1'b0, 1'b1);
    rdchk(A_STAT, 8'h03);
    irqchk(1'b1);
    wr(A_CA, 8'h68);
    rdchk(A_CA, 8'h68);
    wr(A_CA, 8'h28);
    rdchk(A_CA, 8'h28);
    wr(A_IFM, 8'h00);
    wr(A_IFM, 8'h10);
    rdchk(A_CB, 8'h00);
    wr(A_EN, 8'h00);
    irqchk(1'b0);
    wr(A_EN, 8'h02);
    irqchk(1'b1);
    wr(A_CLR, 8'h03);
    rdchk(A_STAT, 8'h00);
    irqchk(1'b0);
    complete_run();
  end
endmodule
`default_nettype wire
